// [shared/edl_pkg.sv]
// Constants and carrier types for the divider nonvolatile load and lock block.
package edl_pkg;
    // Register map, word index on the plain register port.
    localparam logic [2:0] ADDR_DIV_HI = 3'h0;
    localparam logic [2:0] ADDR_DIV_LO = 3'h1;
    localparam logic [2:0] ADDR_NV_HI = 3'h2;
    localparam logic [2:0] ADDR_NV_LO = 3'h3;
    localparam logic [2:0] ADDR_EE_CTRL = 3'h4;
    // Field positions.
    localparam int LOCK_DIS_BIT = 7;
    localparam int DIV_HI_MSB = 2;
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_BUSY_BIT = 3;
    // Widths and reset values.
    localparam int DIVISOR_W = 11;
    localparam logic [7:0] NV_ERASED = 8'hff;
    localparam logic [7:0] DIV_HI_RST = 8'h80;
    localparam logic [7:0] DIV_LO_RST = 8'h00;
    localparam logic [DIVISOR_W-1:0] CNT_RST = 11'h000;
    // One staged program or erase request on a nonvolatile byte.
    typedef struct packed {
        logic sel_hi;
        logic [7:0] data;
    } edl_nv_req_s;
endpackage : edl_pkg

// [hw/edl_divider_nv_lock.sv]
// Divider nonvolatile load, lock and timebase logic behind a plain register port.
`timescale 1ns/1ps
`default_nettype none
module edl_divider_nv_lock (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Register port.
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Divider outputs.
    output logic [edl_pkg::DIVISOR_W-1:0] DIVISOR,
    output logic TIMEBASE_TICK,
    output logic LOCK_ARMED
);
    // Nonvolatile storage has no reset; it powers up erased.
    logic [7:0] nv_hi_r = edl_pkg::NV_ERASED;
    logic [7:0] nv_lo_r = edl_pkg::NV_ERASED;
    logic [7:0] div_hi_r;
    logic [7:0] div_lo_r;
    logic load_pend_r;
    logic latch_r;
    logic erase_r;
    logic busy_r;
    edl_pkg::edl_nv_req_s req_r;
    logic [edl_pkg::DIVISOR_W-1:0] cnt_r;
    logic [7:0] rdata_r;

    // Address decode and write qualification.
    wire logic wr_hi = REG_WR && (REG_ADDR == edl_pkg::ADDR_DIV_HI);
    wire logic wr_lo = REG_WR && (REG_ADDR == edl_pkg::ADDR_DIV_LO);
    wire logic wr_nv_hi = REG_WR && (REG_ADDR == edl_pkg::ADDR_NV_HI);
    wire logic wr_nv_lo = REG_WR && (REG_ADDR == edl_pkg::ADDR_NV_LO);
    wire logic wr_ctrl = REG_WR && (REG_ADDR == edl_pkg::ADDR_EE_CTRL);
    wire logic lock_armed = !div_hi_r[edl_pkg::LOCK_DIS_BIT];
    wire logic div_wr_ok = !load_pend_r && !lock_armed && !latch_r;
    wire logic go_req = wr_ctrl && REG_WDATA[edl_pkg::CTRL_GO_BIT] && latch_r;
    wire logic go_ok = go_req && !lock_armed && !busy_r && !load_pend_r;
    wire logic [edl_pkg::DIVISOR_W-1:0] divisor = {div_hi_r[edl_pkg::DIV_HI_MSB:0], div_lo_r};
    // A count already past a freshly lowered divisor ends the period at once.
    // An equality test would instead run the counter round all eleven bits before the next tick.
    wire logic tick = (divisor != edl_pkg::CNT_RST) && (cnt_r >= divisor - 11'h001);
    wire logic op_done = busy_r && tick;
    wire logic [7:0] nv_sel = req_r.sel_hi ? nv_hi_r : nv_lo_r;
    // Programming only clears bits, as in an EEPROM cell; erase returns all ones.
    wire logic [7:0] nv_new = erase_r ? edl_pkg::NV_ERASED : (nv_sel & req_r.data);
    wire logic [7:0] ctrl_rd = {4'h0, busy_r, 1'b0, erase_r, latch_r};

    // Read selection; unmapped words read as zero.
    wire logic [7:0] rd_mux =
        (REG_ADDR == edl_pkg::ADDR_DIV_HI) ? div_hi_r :
        (REG_ADDR == edl_pkg::ADDR_DIV_LO) ? div_lo_r :
        (REG_ADDR == edl_pkg::ADDR_NV_HI) ? nv_hi_r :
        (REG_ADDR == edl_pkg::ADDR_NV_LO) ? nv_lo_r :
        (REG_ADDR == edl_pkg::ADDR_EE_CTRL) ? ctrl_rd : 8'h00;

    // Nonvolatile bytes change only at the end of an accepted operation, never by reset.
    always_ff @(posedge CORE_CLK) begin
        if (op_done && req_r.sel_hi) begin
            nv_hi_r <= nv_new;
        end
        if (op_done && !req_r.sel_hi) begin
            nv_lo_r <= nv_new;
        end
    end

    // A flop under async reset takes only a constant, so the copy runs one cycle after release.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            load_pend_r <= 1'b1;
        end else begin
            load_pend_r <= 1'b0;
        end
    end

    // Volatile divider registers; a zero lock bit in storage reloads as zero forever.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_hi_r <= edl_pkg::DIV_HI_RST;
            div_lo_r <= edl_pkg::DIV_LO_RST;
        end else if (load_pend_r) begin
            div_hi_r <= nv_hi_r;
            div_lo_r <= nv_lo_r;
        end else begin
            if (wr_hi && div_wr_ok) begin
                div_hi_r <= REG_WDATA;
            end
            if (wr_lo && div_wr_ok) begin
                div_lo_r <= REG_WDATA;
            end
        end
    end

    // Latch, mode and staged request; control writes are ignored while busy, so a started operation cannot be cancelled.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            latch_r <= 1'b0;
            erase_r <= 1'b0;
            busy_r <= 1'b0;
            req_r <= '0;
        end else begin
            if (wr_ctrl && !busy_r) begin
                latch_r <= REG_WDATA[edl_pkg::CTRL_LATCH_BIT];
                erase_r <= REG_WDATA[edl_pkg::CTRL_ERASE_BIT];
            end
            if ((wr_nv_hi || wr_nv_lo) && latch_r && !busy_r) begin
                req_r <= '{sel_hi: wr_nv_hi, data: REG_WDATA};
            end
            if (op_done) begin
                busy_r <= 1'b0;
            end else if (go_ok) begin
                busy_r <= 1'b1;
            end
        end
    end

    // Timebase counter; a zero divisor stops the tick rather than dividing by zero.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_r <= edl_pkg::CNT_RST;
        end else if (tick || divisor == edl_pkg::CNT_RST) begin
            cnt_r <= edl_pkg::CNT_RST;
        end else begin
            cnt_r <= cnt_r + 11'h001;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= REG_RD ? rd_mux : 8'h00;
        end
    end

    // Outputs.
    assign REG_RDATA = rdata_r;
    assign DIVISOR = divisor;
    assign TIMEBASE_TICK = tick;
    assign LOCK_ARMED = lock_armed;

    // Checks on the load, lock and divider behaviour.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    a_reset_load_copy: assert property (load_pend_r |=>
        (div_hi_r == $past(nv_hi_r)) && (div_lo_r == $past(nv_lo_r)))
        else $error("Divider registers not loaded from storage after reset.");
    a_lock_freezes_div: assert property ((!load_pend_r && lock_armed && (wr_hi || wr_lo)) |=>
        $stable(div_hi_r) && $stable(div_lo_r))
        else $error("Locked divider register changed on a write.");
    a_lock_guards_nv: assert property ((lock_armed && !busy_r && !load_pend_r) |=>
        $stable(nv_hi_r) && $stable(nv_lo_r) && !busy_r)
        else $error("Storage changed or operation started while locked.");
    a_div_write_ok: assert property ((wr_lo && div_wr_ok) |=>
        div_lo_r == $past(REG_WDATA))
        else $error("Permitted divisor write did not take effect.");
    a_latch_blocks_div: assert property ((latch_r && !load_pend_r && wr_lo) |=>
        $stable(div_lo_r))
        else $error("Divisor written while latch set.");
    a_nv_not_active: assert property ((!load_pend_r && !REG_WR) |=>
        $stable(div_hi_r) && $stable(div_lo_r))
        else $error("Active divisor moved without a write or reset.");
    a_erase_all_ones: assert property ((op_done && erase_r) |=>
        nv_sel == edl_pkg::NV_ERASED)
        else $error("Erased storage byte does not read all ones.");
    a_tick_spacing: assert property ((tick ##1 (divisor > 11'h001)) |->
        !TIMEBASE_TICK)
        else $error("Timebase ticks too close together.");
    a_blocked_silent: assert property ((go_req && lock_armed && !busy_r) |=>
        !busy_r && (ctrl_rd[edl_pkg::CTRL_BUSY_BIT] == 1'b0))
        else $error("Blocked request raised busy.");
    a_read_next_cycle: assert property ((REG_RD && REG_ADDR == edl_pkg::ADDR_DIV_LO) |=>
        REG_RDATA == $past(div_lo_r))
        else $error("Divisor read data wrong or late.");

    c_program_done: cover property (op_done && !erase_r);
    c_erase_done: cover property (op_done && erase_r);
    c_lock_armed_load: cover property (load_pend_r ##1 lock_armed);
    c_tick_seen: cover property (tick);
endmodule : edl_divider_nv_lock
`default_nettype wire

// [bench/tb_edl_divider_nv_lock.sv]
// Self-checking testbench for the divider nonvolatile load and lock block.
`timescale 1ns/1ps
`default_nettype none
module tb_edl_divider_nv_lock;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [10:0] divisor;
    logic timebase_tick;
    logic lock_armed;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] rv;
    // Device under test, all inputs driven by the bench.
    edl_divider_nv_lock dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .DIVISOR(divisor), .TIMEBASE_TICK(timebase_tick), .LOCK_ARMED(lock_armed));
    // Free-running 100 MHz clock.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8
    task automatic chk11(input logic [10:0] got, input logic [10:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk11
    // Reset held three cycles; first request waits for the second edge after release.
    task automatic do_reset();
        @(posedge core_clk) reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : do_reset
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk) begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
        end
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe, so it is sampled just after that edge.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk) begin
            reg_addr <= a;
            reg_rd <= 1'b1;
        end
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Bounded poll of the busy flag; a hang ends the run as a mismatch.
    task automatic wait_idle();
        for (int i = 0; i < 2000; i++) begin
            rd(edl_pkg::ADDR_EE_CTRL, rv);
            if (rv[edl_pkg::CTRL_BUSY_BIT] === 1'b0) return;
        end
        n_mismatch++;
        $display("FAIL t=%0t busy never cleared", $time);
        conclude();
    endtask : wait_idle
    task automatic nv_op(input logic [2:0] a, input logic [7:0] d, input logic erase);
        wr(edl_pkg::ADDR_EE_CTRL, {6'h00, erase, 1'b1});
        wr(a, d);
        wr(edl_pkg::ADDR_EE_CTRL, {5'h00, 1'b1, erase, 1'b1});
    endtask : nv_op
    task automatic t_defaults_and_tick();
        int n = 0;
        rd(edl_pkg::ADDR_DIV_HI, rv);
        chk8(rv & 8'h87, 8'h87, "erased hi load");
        chk11(divisor, 11'h7ff, "erased divisor");
        chk8({7'h00, lock_armed}, 8'h00, "unlocked");
        wr(edl_pkg::ADDR_DIV_HI, 8'h80);
        wr(edl_pkg::ADDR_DIV_LO, 8'h05);
        rd(edl_pkg::ADDR_DIV_LO, rv);
        chk8(rv, 8'h05, "div lo write");
        repeat (20) begin
            @(posedge core_clk) #1 n += int'(timebase_tick === 1'b1);
        end
        chk8(8'(n), 8'h04, "ticks in 20");
        $display("test defaults_and_tick done");
    endtask : t_defaults_and_tick
    task automatic t_program_unlocked();
        nv_op(edl_pkg::ADDR_NV_LO, 8'h20, 1'b0);
        wr(edl_pkg::ADDR_DIV_LO, 8'h09);
        wait_idle();
        chk11(divisor, 11'h005, "latch blocks, no early load");
        rd(edl_pkg::ADDR_NV_LO, rv);
        chk8(rv, 8'h20, "nv lo programmed");
        nv_op(edl_pkg::ADDR_NV_LO, 8'h00, 1'b1);
        wait_idle();
        rd(edl_pkg::ADDR_NV_LO, rv);
        chk8(rv, 8'hff, "nv lo erased");
        nv_op(edl_pkg::ADDR_NV_LO, 8'h20, 1'b0);
        wait_idle();
        rd(edl_pkg::ADDR_NV_LO, rv);
        chk8(rv, 8'h20, "nv lo reprogrammed");
        do_reset();
        chk11(divisor, 11'h720, "reset loads nv");
        nv_op(edl_pkg::ADDR_NV_HI, 8'h03, 1'b0);
        wait_idle();
        chk8({7'h00, lock_armed}, 8'h00, "lock waits reset");
        do_reset();
        chk8({7'h00, lock_armed}, 8'h01, "lock armed");
        chk11(divisor, 11'h320, "locked divisor");
        $display("test program_unlocked done");
    endtask : t_program_unlocked
    task automatic t_locked();
        wr(edl_pkg::ADDR_DIV_LO, 8'h11);
        wr(edl_pkg::ADDR_DIV_HI, 8'h87);
        rd(edl_pkg::ADDR_DIV_HI, rv);
        chk8(rv & 8'h87, 8'h03, "div hi frozen");
        chk11(divisor, 11'h320, "divisor frozen");
        nv_op(edl_pkg::ADDR_NV_LO, 8'h00, 1'b1);
        repeat (1000) @(posedge core_clk);
        rd(edl_pkg::ADDR_EE_CTRL, rv);
        chk8({7'h00, rv[edl_pkg::CTRL_BUSY_BIT]}, 8'h00, "no busy");
        rd(edl_pkg::ADDR_NV_LO, rv);
        chk8(rv, 8'h20, "erase refused");
        do_reset();
        chk8({7'h00, lock_armed}, 8'h01, "lock permanent");
        rd(edl_pkg::ADDR_NV_HI, rv);
        chk8(rv, 8'h03, "nv kept over reset");
        $display("test locked done");
    endtask : t_locked
    // Main sequence.
    initial begin
        do_reset();
        t_defaults_and_tick();
        t_program_unlocked();
        t_locked();
        conclude();
    end
endmodule : tb_edl_divider_nv_lock
`default_nettype wire
